// >>> ext_bus_master.sv
// Master side of the external synchronous bus: single read and write cycles.
// Assumes bus inputs are synchronous to core_clk and sampled directly.
module ext_bus_master
    import ext_bus_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Request port
    input wire logic req_valid,
    output logic req_ready,
    input wire req_t req,
    // Response port
    output logic rsp_valid,
    output rsp_t rsp,
    // Bus monitor
    input wire logic mon_enable,
    input wire logic [MON_W-1:0] mon_limit,
    // External bus
    output logic [ADDR_OUT_W-1:0] addr_out,
    output logic [1:0] access_class,
    output logic access_mode_out,
    output logic read_not_write,
    output logic [1:0] xfer_size_code,
    output logic xfer_start_n,
    output logic [31:0] data_out,
    output logic data_oe_n,
    input wire logic [31:0] data_in,
    input wire logic xfer_ack_n
);
    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_WAIT} state_t;

    state_t state;
    req_t cur;
    logic [1:0] cur_off;
    logic [2:0] beat;
    logic [MON_W-1:0] mon_count;
    logic [31:0] rdata_acc;
    logic [31:0] lanes_q;
    logic [1:0] size_q;

    // FIFO drain side
    wire logic fifo_valid;
    req_t fifo_req;
    wire logic fifo_pop = (state == ST_IDLE);

    req_fifo #(
        .WIDTH($bits(req_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .in_valid(req_valid),
        .in_ready(req_ready),
        .in_data(req),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_req)
    );

    // Illegal start offsets are refused before any bus cycle [RULE4]
    wire logic word_odd = (fifo_req.op == OP_WORD) && fifo_req.addr[0];
    wire logic long_off = ((fifo_req.op == OP_LONG) || (fifo_req.op == OP_LINE))
                          && (fifo_req.addr[1:0] != 2'h0);
    wire logic req_bad = word_odd || long_off;
    wire logic take = fifo_valid && (state == ST_IDLE);

    // Bytes per bus cycle and cycle count
    wire logic [2:0] op_b = op_bytes(cur.op);
    wire logic [2:0] port_b = port_bytes(cur.port);
    wire logic [2:0] beat_b = (op_b < port_b) ? op_b : port_b;
    wire logic [2:0] beats_total = (port_b == 3'h1) ? op_b :
                                   ((port_b == 3'h2) && (op_b == 3'h4)) ? 3'h2 : 3'h1;
    wire logic last_beat = (beat == beats_total - 3'h1);

    // Size code from operand and port, bursting inhibited [RULE6]
    wire logic [1:0] next_size = (beat_b == 3'h1) ? SIZE_BYTE :
                                 (beat_b == 3'h2) ? SIZE_WORD : SIZE_LONG;

    // Write lanes for the current offset
    logic [31:0] mux_lanes;
    lane_mux u_mux (
        .op(cur.op),
        .off(cur_off),
        .operand(cur.wdata),
        .lanes(mux_lanes)
    );

    // Read byte gathering from lanes into operand positions
    logic [31:0] merged;
    always_comb begin
        logic [2:0] kk;
        logic [1:0] opj;
        logic [1:0] lane;
        logic covered;
        merged = rdata_acc;
        kk = 3'h0;
        opj = 2'h0;
        lane = 2'h0;
        covered = 1'b0;
        for (int k = 0; k < 4; k++) begin
            kk = 3'(k);
            covered = (kk >= {1'b0, cur_off}) && (kk < ({1'b0, cur_off} + beat_b));
            // Operand byte index from offset [RULE22]
            opj = 2'(kk - {1'b0, cur.addr[1:0]} + 3'h4 - op_b);
            // Lane per port width [RULE2] [RULE3] [RULE21]
            lane = (cur.port == PORT_32) ? kk[1:0] :
                   (cur.port == PORT_16) ? {1'b0, kk[0]} : 2'h0;
            if (covered) begin
                merged[8*(3-opj) +: 8] = data_in[8*(3-lane) +: 8];
            end
        end
    end

    wire logic acked = (state == ST_WAIT) && !xfer_ack_n;
    wire logic timed_out = (state == ST_WAIT) && xfer_ack_n && mon_enable
                           && (mon_count >= mon_limit);
    wire logic [1:0] next_off = 2'(cur_off + beat_b[1:0]);

    // Sequencer
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (take && !req_bad) begin
                        state <= ST_START;
                    end
                end
                ST_START: begin
                    // Strobe lasts one clock only [RULE8]
                    state <= ST_WAIT;
                end
                ST_WAIT: begin
                    // Stay in wait states while acknowledge is high and the bus monitor has not timed out [RULE11] [RULE20]
                    if (acked && !last_beat) begin
                        state <= ST_START;
                    end else if (acked || timed_out) begin
                        // Free for a new cycle next clock [RULE23]
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Request capture and beat advance
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cur <= '0;
            cur_off <= 2'h0;
            beat <= 3'h0;
        end else if (take) begin
            // Offset from low address bits [RULE1]
            cur <= fifo_req;
            cur_off <= fifo_req.addr[1:0];
            beat <= 3'h0;
        end else if (acked && !last_beat) begin
            // Next offset, e.g. 00 then 10 for a 16-bit port [RULE16]
            cur_off <= next_off;
            beat <= beat + 3'h1;
        end
    end

    // Lane and size registers, loaded in the first clock
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            lanes_q <= 32'h00000000;
            size_q <= SIZE_LONG;
        end else if (state == ST_START) begin
            lanes_q <= mux_lanes;
            size_q <= next_size;
        end
    end

    // Bus monitor counter [RULE12]
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mon_count <= '0;
        end else if (state == ST_START) begin
            mon_count <= '0;
        end else if ((state == ST_WAIT) && (mon_count != '1)) begin
            mon_count <= mon_count + 1'b1;
        end
    end

    // Read accumulation and response
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdata_acc <= 32'h00000000;
            rsp_valid <= 1'b0;
            rsp <= '0;
        end else begin
            rsp_valid <= 1'b0;
            if (take) begin
                rdata_acc <= 32'h00000000;
                if (req_bad) begin
                    rsp_valid <= 1'b1;
                    rsp <= '{rdata: 32'h00000000, bus_err: 1'b0, refused: 1'b1};
                end
            end else if (acked) begin
                // Capture on sampled acknowledge [RULE10]
                rdata_acc <= merged;
                if (last_beat) begin
                    rsp_valid <= 1'b1;
                    rsp <= '{rdata: cur.write ? 32'h00000000 : merged,
                             bus_err: 1'b0, refused: 1'b0};
                end
            end else if (timed_out) begin
                // Internal bus error ends the cycle [RULE12]
                rsp_valid <= 1'b1;
                rsp <= '{rdata: 32'h00000000, bus_err: 1'b1, refused: 1'b0};
            end
        end
    end

    // Bus outputs [RULE5] [RULE17]
    wire logic in_cycle = (state == ST_START) || (state == ST_WAIT);
    assign addr_out = {cur.addr[ADDR_OUT_W-1:2], cur_off};
    assign access_class = cur.access_class;
    // Code or data first clock, then privilege [RULE7]
    assign access_mode_out = (state == ST_START) ? cur.code : cur.supervisor;
    // Direction high for reads, low for writes [RULE6] [RULE17]
    assign read_not_write = !(in_cycle && cur.write);
    assign xfer_size_code = (state == ST_START) ? next_size : size_q;
    assign xfer_start_n = (state != ST_START); // [RULE8]
    // Write data from second clock, held through waits [RULE18] [RULE20]
    assign data_out = lanes_q;
    assign data_oe_n = !((state == ST_WAIT) && cur.write);
endmodule : ext_bus_master

// >>> ext_bus_master_asserts.sv
// Concurrent checks on the bus master's ports.
// Assumes one clock domain and a synchronous active-low reset.
module ext_bus_master_asserts
    import ext_bus_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Response and monitor
    input wire logic rsp_valid,
    input wire rsp_t rsp,
    input wire logic mon_enable,
    input wire logic [MON_W-1:0] mon_limit,
    // External bus
    input wire logic [ADDR_OUT_W-1:0] addr_out,
    input wire logic read_not_write,
    input wire logic [1:0] xfer_size_code,
    input wire logic xfer_start_n,
    input wire logic [31:0] data_out,
    input wire logic data_oe_n,
    input wire logic xfer_ack_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_start;
        $fell(xfer_start_n);
    endsequence
    sequence s_err_wait;
        s_start ##1 (xfer_ack_n && mon_enable && mon_limit == 8'h02) [*3];
    endsequence
    chk_start_single: assert property (s_start |=> xfer_start_n)
        else $error("start strobe longer than one clock");
    chk_wait_holds: assert property (s_start ##1 (xfer_ack_n && !mon_enable)
        |=> xfer_start_n && !rsp_valid) else $error("cycle ended without ack");
    chk_bus_err_time: assert property (s_err_wait |=> rsp_valid && rsp.bus_err)
        else $error("bus error not at monitor limit");
    chk_addr_steady: assert property (s_start |=> $stable(addr_out) && $stable(xfer_size_code))
        else $error("address or size moved in cycle");
    chk_write_oe: assert property (!xfer_start_n && !read_not_write
        |=> !data_oe_n && !read_not_write) else $error("write data not driven");
    chk_write_hold: assert property (!data_oe_n && xfer_ack_n && !mon_enable
        |=> !data_oe_n && $stable(data_out)) else $error("write data dropped in wait");
    chk_oe_write_only: assert property (!data_oe_n |-> !read_not_write && xfer_start_n)
        else $error("data driven outside write");
    chk_rsp_after_ack: assert property (rsp_valid && !rsp.bus_err && !rsp.refused
        |-> !$past(xfer_ack_n) && $past(xfer_start_n)) else $error("response without ack");
    chk_size_legal: assert property (!xfer_start_n |-> xfer_size_code != 2'h3)
        else $error("line size code issued");
    chk_rsp_idle: assert property (rsp_valid |-> xfer_start_n)
        else $error("strobe held at response");
endmodule : ext_bus_master_asserts
bind ext_bus_master ext_bus_master_asserts ext_bus_master_asserts_inst (
    .core_clk(core_clk), .rst_n(rst_n), .rsp_valid(rsp_valid), .rsp(rsp),
    .mon_enable(mon_enable), .mon_limit(mon_limit), .addr_out(addr_out),
    .read_not_write(read_not_write), .xfer_size_code(xfer_size_code),
    .xfer_start_n(xfer_start_n), .data_out(data_out), .data_oe_n(data_oe_n),
    .xfer_ack_n(xfer_ack_n));

// >>> ext_bus_master_tb_top.sv
// Testbench: reference model with queues, partner slave, self checks.
// Assumes package, design, slave and checker compiled before it.
module ext_bus_master_tb_top
    import ext_bus_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    req_t req = '0;
    logic mon_enable = 1'b0;
    logic [7:0] mon_limit = 8'h00;
    logic [7:0] slave_wait = 8'h00;
    logic req_ready, rsp_valid, access_mode_out, read_not_write, xfer_start_n, data_oe_n;
    logic xfer_ack_n;
    rsp_t rsp;
    logic [27:0] addr_out;
    logic [1:0] access_class, xfer_size_code;
    logic [31:0] data_out, data_in, seed = 32'd92187, x;
    logic [7:0] mdl [256];
    logic [33:0] exp_q [$];
    logic exp_err = 1'b0;
    logic saw_full = 1'b0;
    logic in_c2 = 1'b0;
    logic [3:0] attr_q [$];
    logic [33:0] seen_rsp, exp_rsp;
    int errors = 0;
    int check_count = 0;
    always #5 core_clk = ~core_clk;
    ext_bus_master ext_bus_master_inst (.core_clk(core_clk), .rst_n(rst_n),
        .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
        .rsp(rsp), .mon_enable(mon_enable), .mon_limit(mon_limit), .addr_out(addr_out),
        .access_class(access_class), .access_mode_out(access_mode_out),
        .read_not_write(read_not_write), .xfer_size_code(xfer_size_code),
        .xfer_start_n(xfer_start_n), .data_out(data_out), .data_oe_n(data_oe_n),
        .data_in(data_in), .xfer_ack_n(xfer_ack_n));
    ext_bus_slave ext_bus_slave_inst (.core_clk(core_clk), .wait_cycles(slave_wait),
        .addr_out(addr_out), .read_not_write(read_not_write),
        .xfer_size_code(xfer_size_code), .xfer_start_n(xfer_start_n),
        .data_out(data_out), .data_in(data_in), .xfer_ack_n(xfer_ack_n));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic check(input logic [33:0] seen, input logic [33:0] expv);
        check_count++;
        if (seen !== expv) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask : check
    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test
    // Model a request, then hand it over; port chosen by address bits 7:6
    task automatic run_one(input logic wr, input logic [1:0] op, input logic [1:0] prt,
                           input logic [1:0] off, input logic [31:0] v, input logic [7:0] w);
        req_t r;
        logic [7:0] a;
        logic [31:0] rd;
        int nb;
        a = {prt, v[3:0], off};
        nb = (op == 2'h0) ? 1 : (op == 2'h1) ? 2 : 4;
        rd = '0;
        r = '{wr, op_size_t'(op), port_size_t'(prt), v[4], v[5], v[7:6], {24'h0, a}, v};
        if ((op == 2'h1 && off[0]) || (op[1] && off != 2'h0)) begin
            exp_q.push_back({32'h0, 2'b01});
        end else if (exp_err) begin
            exp_q.push_back({32'h0, 2'b10});
        end else begin
            for (int i = 0; i < nb; i++) begin
                if (wr) mdl[a + 8'(i)] = v[8 * (nb - 1 - i) +: 8];
                rd = {rd[23:0], mdl[a + 8'(i)]};
            end
            exp_q.push_back({wr ? 32'h0 : rd, 2'b00});
        end
        // Class, privilege and code flags of every request that reaches the bus
        if (!exp_q[$][0]) attr_q.push_back({v[7:6], v[5], v[4]});
        @(posedge core_clk);
        req <= r;
        req_valid <= 1'b1;
        slave_wait <= w;
        do @(negedge core_clk); while (req_ready !== 1'b1);
        @(posedge core_clk);
        req_valid <= 1'b0;
    endtask : run_one
    task automatic wait_idle(input string name);
        for (int k = 0; k < 3000 && exp_q.size() != 0; k++) @(posedge core_clk);
        check({2'h0, 32'(exp_q.size())}, 34'h0);
        $display("test done: %s", name);
        @(posedge core_clk);
    endtask : wait_idle
    // Every result against the model, lanes via write then read back
    always @(negedge core_clk) begin
        if (req_valid && req_ready === 1'b0) saw_full = 1'b1;
        if (rst_n && in_c2)
            check({33'h0, access_mode_out}, {33'h0, attr_q[0][1]});
        in_c2 = rst_n && xfer_start_n === 1'b0;
        if (in_c2)
            check({32'h0, access_class}, {32'h0, attr_q[0][3:2]});
        if (in_c2)
            check({33'h0, access_mode_out}, {33'h0, attr_q[0][0]});
        if (rst_n && rsp_valid === 1'b1) begin
            seen_rsp = {rsp.rdata, rsp.bus_err, rsp.refused};
            exp_rsp = (exp_q.size() > 0) ? exp_q.pop_front() : ~seen_rsp;
            if (!exp_rsp[0] && attr_q.size() > 0) void'(attr_q.pop_front());
            check(seen_rsp, exp_rsp);
        end
    end
    initial begin
        for (int i = 0; i < 256; i++) mdl[i] = 8'(i * 37 ^ 90);
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int t = 0; t < 96; t++) begin
            x = xs();
            run_one(!t[0], 2'(t >> 1), 2'(t >> 5), 2'(t >> 3), x, {6'h0, x[9:8]});
        end
        wait_idle("all sizes, ports and offsets");
        mon_enable <= 1'b1;
        mon_limit <= 8'hFF;
        for (int t = 0; t < 100; t++) begin
            x = xs();
            run_one(x[20], x[22:21], (x[24:23] == 2'h3) ? 2'h2 : x[24:23], x[26:25], x,
                    {6'h0, x[9:8]});
        end
        wait_idle("random traffic");
        mon_limit <= 8'h20;
        exp_err = 1'b1;
        repeat (10) run_one(1'b0, 2'h2, 2'h0, 2'h0, xs(), 8'hFF);
        wait_idle("fifo full with timeouts");
        check({33'h0, saw_full}, 34'h1);
        mon_limit <= 8'h02;
        run_one(1'b0, 2'h0, 2'h1, 2'h1, xs(), 8'hFF);
        wait_idle("short monitor limit");
        stop_test();
    end
    initial begin
        #200000;
        errors++;
        stop_test();
    end
endmodule : ext_bus_master_tb_top

// >>> ext_bus_pkg.sv
// Constants, types and helpers of the external bus master.
// Assumes a single core_clk domain; bus pins are synchronous to it.
// Contract
// RULE1 - Upper address bits give longword base; two low bits give byte offset 0..3.
// RULE2 - 32-bit slave returns offset 0 on top lane down to offset 3 on bottom lane.
// RULE3 - 16-bit slave uses top lane for even, next for odd; 8-bit uses top lane.
// RULE4 - Never issue word at odd offset, or longword or line at non-zero offset.
// RULE5 - First clock drives address, class, mode, direction, size and start strobe low.
// RULE6 - Direction high for reads; size code 00 longword, 10 word.
// RULE7 - Mode output shows code versus data first, then supervisor versus user.
// RULE8 - Start strobe is low for exactly the first clock of each cycle.
// RULE9 - On reads the slave drives data on its lanes and asserts acknowledge.
// RULE10 - Acknowledge sampled at end of second clock; if low, data captured, cycle ends.
// RULE11 - While acknowledge high, wait states added, resampled every rising edge.
// RULE12 - Enabled bus monitor ends an unanswered cycle with a bus error.
// RULE13 - Byte writes copy the low operand byte onto lanes per offset.
// RULE14 - Word writes use upper lanes, also lower at offset 2, low byte only at odd.
// RULE15 - Longword writes: all bytes at 0, then bytes 1, 2-3, 3 per offset.
// RULE16 - Longword to 16-bit port runs offsets 00 then 10 on the upper lanes.
// RULE17 - Writes drive direction low in first clock, else as for reads.
// RULE18 - Write data driven from second clock; acknowledge sampled at its end.
// RULE19 - Slave acknowledges a write only when ready and captures at that edge.
// RULE20 - Write data held steady through wait states until acknowledge.
// RULE21 - Slave ports sit on all lanes, upper sixteen, or uppermost eight.
// RULE22 - Operand bytes numbered 0 as most significant to 3 least significant.
// RULE23 - After acknowledge or bus error the strobe is released and a new cycle may start.
package ext_bus_pkg;

    typedef enum logic [1:0] {OP_BYTE, OP_WORD, OP_LONG, OP_LINE} op_size_t;
    typedef enum logic [1:0] {PORT_32, PORT_16, PORT_8} port_size_t;

    localparam logic [1:0] SIZE_LONG = 2'h0;
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam int FIFO_DEPTH = 8;
    localparam int MON_W = 8;
    localparam int ADDR_OUT_W = 28;

    typedef struct packed {
        logic write;
        op_size_t op;
        port_size_t port;
        logic code;
        logic supervisor;
        logic [1:0] access_class;
        logic [31:0] addr;
        logic [31:0] wdata;
    } req_t;

    typedef struct packed {
        logic [31:0] rdata;
        logic bus_err;
        logic refused;
    } rsp_t;

    function automatic logic [2:0] op_bytes(input op_size_t op);
        case (op)
            OP_BYTE: op_bytes = 3'h1;
            OP_WORD: op_bytes = 3'h2;
            default: op_bytes = 3'h4;
        endcase
    endfunction : op_bytes

    function automatic logic [2:0] port_bytes(input port_size_t port);
        case (port)
            PORT_32: port_bytes = 3'h4;
            PORT_16: port_bytes = 3'h2;
            default: port_bytes = 3'h1;
        endcase
    endfunction : port_bytes

endpackage : ext_bus_pkg

// >>> ext_bus_slave.sv
// Partner slave model: byte memory behind the external bus.
// Assumes port size decoded from address bits 7:6, pins synchronous.
module ext_bus_slave
    import ext_bus_pkg::*;
(
    // Clock and wait control
    input wire logic core_clk,
    input wire logic [7:0] wait_cycles,
    // Bus from the master
    input wire logic [27:0] addr_out,
    input wire logic read_not_write,
    input wire logic [1:0] xfer_size_code,
    input wire logic xfer_start_n,
    input wire logic [31:0] data_out,
    // Answer to the master
    output logic [31:0] data_in,
    output logic xfer_ack_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [256];
    logic [7:0] a = 8'h00;
    logic [7:0] cnt = 8'h00;
    logic [1:0] sz = 2'h0;
    logic busy = 1'b0;
    logic rd = 1'b1;
    logic [31:0] noise = 32'h0;
    // Lane of a byte address: 32, 16 or 8 bit port
    function automatic int lane(input logic [7:0] x);
        return (x[7:6] == 2'h0) ? int'(x[1:0]) : (x[7:6] == 2'h1) ? int'(x[0]) : 0;
    endfunction : lane
    function automatic int nbytes(input logic [1:0] s);
        return (s == 2'h1) ? 1 : (s == 2'h2) ? 2 : 4;
    endfunction : nbytes
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i * 37 ^ 90);
    // Never answers when wait_cycles is FF
    assign xfer_ack_n = !(busy && cnt >= wait_cycles && wait_cycles != 8'hFF);
    always_comb begin
        data_in = noise;
        for (int i = 0; i < 4; i++) begin
            if (busy && rd && i < nbytes(sz))
                data_in[8 * (3 - lane(a + 8'(i))) +: 8] = mem[a + 8'(i)];
        end
    end
    always @(posedge core_clk) begin
        noise <= {noise[30:0], ~noise[31]};
        if (!xfer_start_n) begin
            busy <= 1'b1;
            a <= addr_out[7:0];
            sz <= xfer_size_code;
            rd <= read_not_write;
            cnt <= 8'h00;
        end else if (busy && !xfer_ack_n) begin
            busy <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                if (!rd && i < nbytes(sz))
                    mem[a + 8'(i)] <= data_out[8 * (3 - lane(a + 8'(i))) +: 8];
            end
        end else if (busy) begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule : ext_bus_slave

// >>> lane_mux.sv
// Write multiplexer from operand bytes to external byte lanes.
// Assumes operand bytes are numbered 0 (top) to 3 (bottom) of the word.
module lane_mux
    import ext_bus_pkg::*;
(
    // Operand and position
    input wire op_size_t op,
    input wire logic [1:0] off,
    input wire logic [31:0] operand,
    // Lanes
    output logic [31:0] lanes
);
    // Operand bytes, most significant first [RULE22]
    wire [7:0] b0 = operand[31:24];
    wire [7:0] b1 = operand[23:16];
    wire [7:0] b2 = operand[15:8];
    wire [7:0] b3 = operand[7:0];

    // Low byte always on top lane, copied per offset [RULE13]
    wire [31:0] byte_lanes = {b3, off[0] ? b3 : 8'h00, (off == 2'h2) ? b3 : 8'h00,
                              (off == 2'h3) ? b3 : 8'h00};
    // Word on upper lanes, duplicated at offset 2 [RULE14]
    wire [31:0] word_lanes = off[0] ? {b3, 24'h000000} :
                             {b2, b3, off[1] ? {b2, b3} : 16'h0000};
    // Longword and line by remaining offset [RULE15]
    wire [31:0] long_lanes = (off == 2'h0) ? {b0, b1, b2, b3} :
                             (off == 2'h1) ? {b1, 24'h000000} :
                             (off == 2'h2) ? {b2, b3, 16'h0000} : {b3, 24'h000000};

    assign lanes = (op == OP_BYTE) ? byte_lanes :
                   (op == OP_WORD) ? word_lanes : long_lanes;
endmodule : lane_mux

// >>> req_fifo.sv
// Request FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
module req_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : req_fifo
